// ### hw/dcf_fifo.sv
// fifo control core: resets, retransmit, mode latch, offset load, flags and bus registers
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
(
  // clock and control
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  // reset and configuration pins
  input  wire logic              full_reset_n,
  input  wire logic              ptr_reset_n,
  input  wire logic              reread_n,
  input  wire logic              mode_sel_serial_in,
  input  wire logic              offset_load_n,
  input  wire logic              ser_load_en_n,
  // write side
  input  wire logic              wr_en_n,
  input  wire logic [DATA_W-1:0] wr_data,
  // read side
  input  wire logic              rd_en_n,
  output logic      [DATA_W-1:0] rd_data,
  // flags
  output logic                   empty_n,
  output logic                   full_n,
  output logic                   in_ready_n,
  output logic                   almost_empty_n,
  output logic                   almost_full_n,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // interrupt
  output logic                   irq
);

  // fifo state
  logic [PTR_W-1:0]  wptr,  next_wptr;
  logic [PTR_W-1:0]  rptr,  next_rptr;
  logic [CNT_W-1:0]  count, next_count;
  logic [DATA_W-1:0] dout,  next_dout;
  logic              fall_through_mode, next_fall_through_mode;
  logic              ser_method, next_ser_method;
  logic [OFS_W-1:0]  ofs_empty, next_ofs_empty;
  logic [OFS_W-1:0]  ofs_full,  next_ofs_full;
  logic [1:0]        par_idx,   next_par_idx;
  logic [1:0]        ft_cnt,    next_ft_cnt;
  logic              reread_hold, next_reread_hold;
  dcf_ft_state_type  ft_state,  next_ft_state;

  // per-cycle strobes
  logic              mem_we;
  logic              wr_take;
  logic              rd_take;
  logic [DATA_W-1:0] mem_q;
  logic [EV_W-1:0]   events;

  // bus state
  logic [EV_W-1:0]   ev_status, next_ev_status;
  logic [EV_W-1:0]   ev_mask,   next_ev_mask;
  logic [31:0]       rdata_q,   next_rdata_q;
  logic              dph_wr,    next_dph_wr;
  logic [7:0]        dph_addr,  next_dph_addr;
  logic              acc;

  dcf_ram u_ram (
    .mclk  (mclk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (wptr),
    .wdata (wr_data),
    .raddr (rptr),
    .rdata (mem_q)
  );

  // fifo next state: resets, writes, offset loading, reads
  always_comb begin
    next_wptr              = wptr;
    next_rptr              = rptr;
    next_count             = count;
    next_dout              = dout;
    next_fall_through_mode = fall_through_mode;
    next_ser_method        = ser_method;
    next_ofs_empty         = ofs_empty;
    next_ofs_full          = ofs_full;
    next_par_idx           = par_idx;
    next_ft_cnt            = ft_cnt;
    next_ft_state          = ft_state;
    next_reread_hold       = 1'b0;
    mem_we                 = 1'b0;
    wr_take                = 1'b0;
    rd_take                = 1'b0;
    events                 = '0;
    if (!full_reset_n) begin
      next_wptr     = RST_PTR;
      next_rptr     = RST_PTR;
      next_count    = RST_CNT;
      next_dout     = RST_DOUT;
      next_par_idx  = 2'h0;
      next_ft_state = FT_IDLE;
      next_fall_through_mode = mode_sel_serial_in;
      next_ser_method = offset_load_n;
      next_ofs_empty  = offset_load_n ? OFS_DEF_LARGE : OFS_DEF_SMALL;
      next_ofs_full   = offset_load_n ? OFS_DEF_LARGE : OFS_DEF_SMALL;
    end else if (!ptr_reset_n) begin
      next_wptr     = RST_PTR;
      next_rptr     = RST_PTR;
      next_count    = RST_CNT;
      next_dout     = RST_DOUT;
      next_par_idx  = 2'h0;
      next_ft_state = FT_IDLE;
    end else begin
      // word store or parallel offset load
      if (!wr_en_n) begin
        if (!offset_load_n && !ser_method) begin
          next_par_idx = par_idx + 2'h1;
          case (par_idx)
            2'h0:    next_ofs_empty[8:0]  = wr_data;
            2'h1:    next_ofs_empty[15:9] = wr_data[6:0];
            2'h2:    next_ofs_full[8:0]   = wr_data;
            default: next_ofs_full[15:9]  = wr_data[6:0];
          endcase
        end else if (count == DEPTH_CNT) begin
          events[EV_OVF] = 1'b1;
        end else begin
          mem_we    = 1'b1;
          wr_take   = 1'b1;
          next_wptr = wptr + 16'h0001;
        end
      end
      if (!ser_load_en_n && ser_method) begin
        {next_ofs_full, next_ofs_empty} = {ofs_full[OFS_W-2:0], ofs_empty, mode_sel_serial_in};
      end
      if (!reread_n) begin
        next_rptr     = RST_PTR;
        next_count    = CNT_W'(next_wptr);
        next_reread_hold  = 1'b1;
        next_ft_state     = FT_IDLE;
        events[EV_REREAD] = 1'b1;
      end else begin
        if (!fall_through_mode) begin
          if (!rd_en_n) begin
            if (count == RST_CNT) begin
              events[EV_UNF] = 1'b1;
            end else begin
              rd_take = 1'b1;
            end
          end
        end else begin
          case (ft_state)
            FT_IDLE: begin
              if (!rd_en_n) begin
                events[EV_UNF] = 1'b1;
              end
              if (count != RST_CNT) begin
                next_ft_state = FT_WAIT;
                next_ft_cnt   = FT_WAIT_INIT;
              end
            end
            FT_WAIT: begin
              if (!rd_en_n) begin
                events[EV_UNF] = 1'b1;
              end
              if (ft_cnt == 2'h0) begin
                rd_take       = 1'b1;
                next_ft_state = FT_VALID;
              end else begin
                next_ft_cnt = ft_cnt - 2'h1;
              end
            end
            FT_VALID: begin
              if (!rd_en_n) begin
                if (count != RST_CNT) begin
                  rd_take = 1'b1;
                end else begin
                  next_ft_state = FT_IDLE;
                end
              end
            end
            default: begin
              next_ft_state = FT_IDLE;
            end
          endcase
        end
        if (rd_take) begin
          next_dout = mem_q;
          next_rptr = rptr + 16'h0001;
        end
        next_count = count + CNT_W'(wr_take) - CNT_W'(rd_take);
      end
      events[EV_FULL]  = wr_take && !rd_take && (count == DEPTH_CNT - 17'h00001);
      events[EV_EMPTY] = rd_take && !wr_take && (count == 17'h00001);
    end
  end

  // fifo registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      wptr              <= RST_PTR;
      rptr              <= RST_PTR;
      count             <= RST_CNT;
      dout              <= RST_DOUT;
      fall_through_mode <= RST_FALL_MODE;
      ser_method        <= RST_SER_METHOD;
      ofs_empty         <= OFS_DEF_SMALL;
      ofs_full          <= OFS_DEF_SMALL;
      par_idx           <= 2'h0;
      ft_cnt            <= 2'h0;
      ft_state          <= FT_IDLE;
      reread_hold       <= 1'b0;
    end else if (ce) begin
      wptr              <= next_wptr;
      rptr              <= next_rptr;
      count             <= next_count;
      dout              <= next_dout;
      fall_through_mode <= next_fall_through_mode;
      ser_method        <= next_ser_method;
      ofs_empty         <= next_ofs_empty;
      ofs_full          <= next_ofs_full;
      par_idx           <= next_par_idx;
      ft_cnt            <= next_ft_cnt;
      ft_state          <= next_ft_state;
      reread_hold       <= next_reread_hold;
    end
  end

  // flags from registered state
  assign rd_data        = dout;
  assign empty_n        = fall_through_mode ? (ft_state != FT_VALID) : ((count != RST_CNT) && !reread_hold);
  assign full_n         = (count != DEPTH_CNT);
  assign in_ready_n     = (count == DEPTH_CNT);
  assign almost_empty_n = (count > CNT_W'(ofs_empty));
  assign almost_full_n  = (count < (DEPTH_CNT - CNT_W'(ofs_full)));

  // bus address phase accepted
  assign acc = hsel && hready && htrans[1] && ce;

  // bus next state: read data, mask write, sticky events
  always_comb begin
    next_dph_wr    = dph_wr;
    next_dph_addr  = dph_addr;
    next_rdata_q   = rdata_q;
    next_ev_mask   = ev_mask;
    next_ev_status = ev_status | events;
    if (dph_wr && (dph_addr == REG_EVENT_MASK)) begin
      next_ev_mask = hwdata[EV_W-1:0];
    end
    if (hready) begin
      next_dph_wr = acc && hwrite;
    end
    if (acc) begin
      next_dph_addr = haddr[7:0];
      next_rdata_q  = 32'h00000000;
      if (!hwrite) begin
        case (haddr[7:0])
          REG_EVENT_STATUS: begin
            next_rdata_q   = 32'(ev_status);
            next_ev_status = events;  // clear on read, new events win
          end
          REG_EVENT_MASK: next_rdata_q = 32'(ev_mask);
          REG_CONFIG: begin
            next_rdata_q[CFG_FALL_BIT]                  = fall_through_mode;
            next_rdata_q[CFG_SER_BIT]                   = ser_method;
            next_rdata_q[CFG_CNT_LSB +: CNT_W]          = count;
          end
          REG_OFFSETS:    next_rdata_q = {ofs_full, ofs_empty};
          default:        next_rdata_q = 32'h00000000;
        endcase
      end
    end
  end

  // bus registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      dph_wr    <= 1'b0;
      dph_addr  <= 8'h00;
      rdata_q   <= 32'h00000000;
      ev_mask   <= RST_MASK;
      ev_status <= RST_EVENTS;
    end else if (ce) begin
      dph_wr    <= next_dph_wr;
      dph_addr  <= next_dph_addr;
      rdata_q   <= next_rdata_q;
      ev_mask   <= next_ev_mask;
      ev_status <= next_ev_status;
    end
  end

  // zero wait, always okay, stalls while frozen
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign irq       = |(ev_status & ev_mask);

endmodule : dcf_fifo

// ### hw/dcf_pkg.sv
// constants and types shared by the dual clock style fifo control block
package dcf_pkg;

  // data path and storage
  localparam int DATA_W = 9;
  localparam int DEPTH  = 65536;
  localparam int PTR_W  = 16;
  localparam int CNT_W  = 17;
  localparam int OFS_W  = 16;

  localparam logic [CNT_W-1:0] DEPTH_CNT = 17'h10000;

  // default flag offsets chosen at full reset
  localparam logic [OFS_W-1:0] OFS_DEF_SMALL = 16'h007F;
  localparam logic [OFS_W-1:0] OFS_DEF_LARGE = 16'h03FF;

  // fall through latency in clock transitions of the read side
  localparam int                FT_TRANSITIONS = 3;
  localparam logic [1:0]        FT_WAIT_INIT   = 2'(FT_TRANSITIONS - 2);

  // reset values of configuration and state
  localparam logic              RST_FALL_MODE  = 1'b0;
  localparam logic              RST_SER_METHOD = 1'b0;
  localparam logic [PTR_W-1:0]  RST_PTR        = 16'h0000;
  localparam logic [CNT_W-1:0]  RST_CNT        = 17'h00000;
  localparam logic [DATA_W-1:0] RST_DOUT       = 9'h000;

  // register byte offsets on the bus
  localparam logic [7:0] REG_EVENT_STATUS = 8'h00;
  localparam logic [7:0] REG_EVENT_MASK   = 8'h04;
  localparam logic [7:0] REG_CONFIG       = 8'h08;
  localparam logic [7:0] REG_OFFSETS      = 8'h0C;

  // event bit positions in status and mask
  localparam int EV_W      = 5;
  localparam int EV_FULL   = 0;
  localparam int EV_EMPTY  = 1;
  localparam int EV_OVF    = 2;
  localparam int EV_UNF    = 3;
  localparam int EV_REREAD = 4;

  localparam logic [EV_W-1:0] RST_EVENTS = 5'h00;
  localparam logic [EV_W-1:0] RST_MASK   = 5'h00;

  // config register field positions
  localparam int CFG_FALL_BIT = 0;
  localparam int CFG_SER_BIT  = 1;
  localparam int CFG_CNT_LSB  = 8;

  // fall through output stage states
  typedef enum logic [1:0] {
    FT_IDLE,
    FT_WAIT,
    FT_VALID
  } dcf_ft_state_type;

endpackage : dcf_pkg

// ### hw/dcf_ram.sv
// storage array of the fifo with one write port and an asynchronous read port
`timescale 1ns/1ps
module dcf_ram
  import dcf_pkg::*;
(
  // clock
  input  wire logic              mclk,
  input  wire logic              ce,
  // write port
  input  wire logic              we,
  input  wire logic [PTR_W-1:0]  waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // read port
  input  wire logic [PTR_W-1:0]  raddr,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [DEPTH];

  // write on enabled edges only
  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // read is combinational, the caller registers it
  assign rdata = mem[raddr];

endmodule : dcf_ram

// ### test/dcf_host.sv
// write side host model streaming counted words into the fifo
`timescale 1ns/1ps
module dcf_host
  import dcf_pkg::*;
(
  // clock and command
  input  wire logic              mclk,
  input  wire logic              go,
  input  wire logic [CNT_W-1:0]  num,
  input  wire logic [DATA_W-1:0] base,
  output logic                   busy,
  // fifo write pins
  output logic                   wr_en_n,
  output logic      [DATA_W-1:0] wr_data
);
  logic [CNT_W-1:0] left;

  initial begin
    busy = 1'b0;
    left = 17'h00000;
    wr_en_n = 1'b1;
    wr_data = 9'h000;
  end

  // one word per edge, idle data toggles so it is never stale
  always @(posedge mclk) begin
    if (go) begin
      left <= num;
      busy <= 1'b1;
      wr_en_n <= 1'b0;
      wr_data <= base;
    end else if (left > 17'h00001) begin
      left <= left - 17'h00001;
      wr_data <= wr_data + 9'h001;
    end else begin
      left <= 17'h00000;
      busy <= 1'b0;
      wr_en_n <= 1'b1;
      wr_data <= ~wr_data;
    end
  end
endmodule : dcf_host

// ### test/dcf_fifo_chk.sv
// checker of reset, retransmit and flag behaviour at the fifo pins
`timescale 1ns/1ps
module dcf_chk
  import dcf_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              ce,
  // control pins
  input wire logic              full_reset_n,
  input wire logic              ptr_reset_n,
  input wire logic              reread_n,
  input wire logic              mode_sel_serial_in,
  input wire logic              offset_load_n,
  input wire logic              wr_en_n,
  input wire logic              rd_en_n,
  // outputs
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              empty_n,
  input wire logic              full_n,
  input wire logic              almost_full_n
);
  logic ft;
  logic next_ft;
  logic run;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || !ce);
  // timing mode seen at the last full reset
  always_comb begin
    next_ft = ft;
    if (!full_reset_n) next_ft = mode_sel_serial_in;
  end
  always_ff @(posedge mclk) begin
    if (srst) ft <= RST_FALL_MODE;
    else if (ce) ft <= next_ft;
  end
  assign run = full_reset_n && ptr_reset_n && reread_n;

  AST_FULL_RST_OUT: assert property (!full_reset_n |=> rd_data == RST_DOUT && full_n && almost_full_n)
    else $error("full reset left output or full flags set");
  AST_PTR_RST_OUT: assert property (full_reset_n && !ptr_reset_n |=> rd_data == RST_DOUT && full_n)
    else $error("pointer reset left output or full flag set");
  AST_FULL_HOLD: assert property (!full_n && run && rd_en_n |=> !full_n)
    else $error("full flag dropped without a read");
  AST_STD_WR: assert property (!ft && !empty_n && !wr_en_n && offset_load_n && run && rd_en_n |=> empty_n)
    else $error("write into empty fifo not stored");
  AST_STD_EMPTY_RD: assert property (!ft && !empty_n && !rd_en_n && wr_en_n && run && $past(reread_n) |=> $stable(rd_data))
    else $error("read of empty fifo changed output");
  AST_STD_REREAD: assert property (!ft && !reread_n && full_reset_n && ptr_reset_n |=> !empty_n)
    else $error("retransmit did not show empty");
  AST_FT_REREAD: assert property (ft && !reread_n && full_reset_n && ptr_reset_n |=> empty_n)
    else $error("retransmit did not drop output ready");
  AST_FT_LAT: assert property ((!full_reset_n && mode_sel_serial_in) ##1 (full_reset_n && wr_en_n)[*2]
    ##1 (!wr_en_n && run && rd_en_n && offset_load_n) |=> empty_n[*3] ##1 !empty_n)
    else $error("first word latency wrong");
  CV_REREAD: cover property (!reread_n && full_reset_n && ptr_reset_n);
  CV_FULL: cover property (!full_n && !wr_en_n);
  CV_FT: cover property (!full_reset_n && mode_sel_serial_in);
endmodule : dcf_chk

bind dcf_fifo dcf_chk u_dcf_chk (.mclk, .srst, .ce, .full_reset_n, .ptr_reset_n, .reread_n, .mode_sel_serial_in,
  .offset_load_n, .wr_en_n, .rd_en_n, .rd_data, .empty_n, .full_n, .almost_full_n);

// ### test/dcf_fifo_tb.sv
// self-checking bench for the fifo control block
`timescale 1ns/1ps
module dcf_fifo_tb
  import dcf_pkg::*;
;
  logic              mclk = 1'b0;
  logic              srst, ce, full_reset_n, ptr_reset_n, reread_n, mode_sel_serial_in, offset_load_n;
  logic              ser_load_en_n, wr_en_n, rd_en_n, hsel, hwrite, hreadyout, hresp, irq, go, busy;
  logic              empty_n, full_n, in_ready_n, almost_empty_n, almost_full_n;
  logic [DATA_W-1:0] wr_data, rd_data, base;
  logic [CNT_W-1:0]  num;
  logic [31:0]       haddr, hwdata, hrdata, rv;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  int                failures = 0;
  int                checks_done = 0;

  always #2.5 mclk = ~mclk;

  dcf_fifo u_dcf_fifo (.mclk, .srst, .ce, .full_reset_n, .ptr_reset_n, .reread_n, .mode_sel_serial_in,
    .offset_load_n, .ser_load_en_n, .wr_en_n, .wr_data, .rd_en_n, .rd_data, .empty_n, .full_n, .in_ready_n,
    .almost_empty_n, .almost_full_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irq);
  dcf_host u_dcf_host (.mclk, .go, .num, .base, .busy, .wr_en_n, .wr_data);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // single ahb transfer, waits on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    rd = hrdata;
  endtask : ahb

  task automatic rg(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] v;
    ahb(1'b0, a, 32'h00000000, v);
    chk(nm, v & m, e);
  endtask : rg

  task automatic push(input logic [CNT_W-1:0] n, input logic [DATA_W-1:0] b);
    num <= n;
    base <= b;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (busy) @(posedge mclk);
  endtask : push

  task automatic pop(input logic [DATA_W-1:0] e);
    rd_en_n <= 1'b0;
    @(posedge mclk);
    rd_en_n <= 1'b1;
    @(posedge mclk);
    chk("rd_data", rd_data, e);
  endtask : pop

  task automatic frst(input logic m, input logic ld);
    full_reset_n <= 1'b0;
    mode_sel_serial_in <= m;
    offset_load_n <= ld;
    @(posedge mclk);
    full_reset_n <= 1'b1;
    offset_load_n <= 1'b1;
    mode_sel_serial_in <= 1'b0;
    @(posedge mclk);
  endtask : frst

  task automatic reread();
    reread_n <= 1'b0;
    @(posedge mclk);
    reread_n <= 1'b1;
    @(posedge mclk);
  endtask : reread

  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    summarize();
  end

  initial begin
    {srst, ce, full_reset_n, ptr_reset_n, reread_n, offset_load_n, ser_load_en_n, rd_en_n, hsel} = 9'h1FF;
    {mode_sel_serial_in, hwrite, go} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    num = 17'h00000;
    base = 9'h000;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rg("config", REG_CONFIG, 32'h00000000);
    rg("offsets", REG_OFFSETS, 32'h007F007F);
    $display("reset values done");
    frst(1'b0, 1'b1);
    rg("config", REG_CONFIG, 32'h00000002);
    rg("offsets", REG_OFFSETS, 32'h03FF03FF);
    for (int i = 31; i >= 0; i--) begin
      ser_load_en_n <= 1'b0;
      mode_sel_serial_in <= 1'(32'h00050003 >> i);
      @(posedge mclk);
    end
    ser_load_en_n <= 1'b1;
    mode_sel_serial_in <= 1'b0;
    rg("offsets", REG_OFFSETS, 32'h00050003);
    rg("config", REG_CONFIG, 32'h00000002);
    $display("serial offsets done");
    push(17'h00003, 9'h1A0);
    rg("count", REG_CONFIG, 32'h00000302);
    chk("almost_empty_n", almost_empty_n, 32'h0);
    chk("almost_full_n", almost_full_n, 32'h1);
    pop(9'h1A0);
    pop(9'h1A1);
    reread();
    chk("empty_n", empty_n, 32'h0);
    pop(9'h1A0);
    pop(9'h1A1);
    pop(9'h1A2);
    ahb(1'b0, REG_EVENT_STATUS, 32'h0, rv);
    pop(9'h1A2);
    chk("irq", irq, 32'h0);
    ahb(1'b1, REG_EVENT_MASK, 32'h00000008, rv);
    @(posedge mclk);
    chk("irq", irq, 32'h1);
    rg("status", REG_EVENT_STATUS, 32'h00000008, 32'h00000008);
    @(posedge mclk);
    chk("irq", irq, 32'h0);
    $display("standard data done");
    push(17'h00002, 9'h055);
    ptr_reset_n <= 1'b0;
    @(posedge mclk);
    ptr_reset_n <= 1'b1;
    @(posedge mclk);
    chk("rd_data", rd_data, 32'h0);
    chk("empty_n", empty_n, 32'h0);
    rg("offsets", REG_OFFSETS, 32'h00050003);
    rg("config", REG_CONFIG, 32'h00000002);
    $display("pointer reset done");
    frst(1'b0, 1'b0);
    rg("offsets", REG_OFFSETS, 32'h007F007F);
    offset_load_n <= 1'b0;
    push(17'h00004, 9'h004);
    offset_load_n <= 1'b1;
    rg("offsets", REG_OFFSETS, 32'h0E060A04);
    rg("config", REG_CONFIG, 32'h00000000);
    $display("parallel offsets done");
    frst(1'b1, 1'b0);
    push(17'h00001, 9'h133);
    repeat (2) @(posedge mclk);
    chk("empty_n", empty_n, 32'h1);
    @(posedge mclk);
    chk("empty_n", empty_n, 32'h0);
    chk("rd_data", rd_data, 32'h133);
    rg("config", REG_CONFIG, 32'h00000001, 32'h00000001);
    reread();
    chk("empty_n", empty_n, 32'h1);
    repeat (3) @(posedge mclk);
    chk("empty_n", empty_n, 32'h0);
    chk("rd_data", rd_data, 32'h133);
    $display("fall through done");
    frst(1'b0, 1'b0);
    push(DEPTH_CNT, 9'h000);
    chk("full_n", full_n, 32'h0);
    chk("in_ready_n", in_ready_n, 32'h1);
    chk("almost_full_n", almost_full_n, 32'h0);
    chk("almost_empty_n", almost_empty_n, 32'h1);
    push(17'h00001, 9'h1FF);
    chk("full_n", full_n, 32'h0);
    rg("count", REG_CONFIG, 32'h01000000);
    rg("status", REG_EVENT_STATUS, 32'h00000017);
    chk("hresp", hresp, 32'h0);
    pop(9'h000);
    $display("full fifo done");
    summarize();
  end
endmodule : dcf_fifo_tb
